// *** hw/mprgc_map.svh ***
// Purpose: register offsets, field positions and timing counts
// Assumes: 200 MHz mclk, byte addressed register bus
// Notes:   counts are derived from times by expression
`ifndef MPRGC_MAP_SVH
`define MPRGC_MAP_SVH

// register byte offsets
`define MPRGC_REG_CTRL       4'h0
`define MPRGC_REG_STATUS     4'h4
`define MPRGC_REG_UART_TX    4'h8
`define MPRGC_REG_UART_RX    4'hC

// control fields
`define MPRGC_CTRL_POS_EN    0
`define MPRGC_CTRL_SLEEP     1
`define MPRGC_CTRL_OFF_CMD   2
`define MPRGC_POS_EN_RST     1'b0
`define MPRGC_SLEEP_RST      1'b0
`define MPRGC_SYNC_IDLE      3'h6
`define MPRGC_TX_IDLE        10'h3FF

// status fields
`define MPRGC_ST_POWERED     0
`define MPRGC_ST_POS_ACT     1
`define MPRGC_ST_IN_RESET    2
`define MPRGC_ST_STATE_LSB   4
`define MPRGC_ST_STATE_MSB   8

// uart fields
`define MPRGC_UART_BUSY      8
`define MPRGC_UART_VALID     8
`define MPRGC_UART_OVERRUN   9
`define MPRGC_UART_BITS      4'hA
`define MPRGC_UART_STOP      4'h9

// clock and timing
`define MPRGC_CLK_HZ         200000000
`define MPRGC_CLK_MHZ        200
`define MPRGC_LPO_HZ         32768
`define MPRGC_AID_HZ         26000000
`define MPRGC_SIM_DOWN_NS    1000
`define MPRGC_MEM_DOWN_NS    1000
`define MPRGC_SIM_DOWN_CYC   ((`MPRGC_SIM_DOWN_NS*`MPRGC_CLK_MHZ+999)/1000)
`define MPRGC_MEM_DOWN_CYC   ((`MPRGC_MEM_DOWN_NS*`MPRGC_CLK_MHZ+999)/1000)
`define MPRGC_BAUD           115200
`define MPRGC_BIT_CYC        (`MPRGC_CLK_HZ/`MPRGC_BAUD)

`endif

// *** hw/mprgc_pkg.sv ***
// Purpose: shared types of the power, reset and positioning block
// Assumes: nothing beyond the map header
// Notes:   power states are one-hot
package mprgc_pkg;

	typedef enum logic [4:0]
	{
		PWR_OFF      = 5'h01,
		PWR_ON       = 5'h02,
		PWR_SIM_DOWN = 5'h04,
		PWR_MEM_DOWN = 5'h08,
		PWR_HELD     = 5'h10
	} mprgc_pwr_state_type;

	typedef struct packed
	{
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} mprgc_avreq_type;

	typedef struct packed
	{
		logic [31:0] readdata;
		logic        waitrequest;
	} mprgc_avrsp_type;

	typedef struct packed
	{
		logic [2:0]          syncA;
		logic [2:0]          syncB;
		mprgc_pwr_state_type pwr;
		logic [15:0]         stepCnt;
		logic                offLatch;
		logic                posEnable;
		logic                hostSleep;
		logic                waitreq;
		logic [31:0]         rdata;
		logic [9:0]          txShift;
		logic [3:0]          txBits;
		logic [15:0]         txBaud;
		logic                txLine;
		logic [7:0]          rxShift;
		logic [3:0]          rxBits;
		logic [15:0]         rxBaud;
		logic                rxBusy;
		logic [7:0]          rxData;
		logic                rxValid;
		logic                rxOverrun;
		logic                rtsN;
		logic                cardPowered;
		logic                simEnable;
		logic                memEnable;
		logic                posPower;
		logic                txBlank;
		logic                txNotice;
		logic                frameStrobe;
		logic                usbRoute;
		logic                i2cRoute;
	} mprgc_state_type;

endpackage

// *** hw/mprgc_clock_gen.sv ***
// Purpose: square clock of a given rate from mclk by phase accumulation
// Assumes: 2*OUT_HZ below IN_HZ
// Notes:   average rate exact, edges jitter by one mclk period
`timescale 1ns/10ps
module mprgc_clock_gen
	import mprgc_pkg::*;
#(
	parameter int OUT_HZ = 32768,
	parameter int IN_HZ  = 200000000
)
(
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic enable,
	output logic      clockOut
);

	typedef struct packed
	{
		logic [28:0] acc;
		logic        level;
	} mprgc_cg_state_type;

	localparam logic [28:0] INC = 29'(2 * OUT_HZ);
	localparam logic [28:0] MOD = 29'(IN_HZ);

	mprgc_cg_state_type st;
	mprgc_cg_state_type next_st;

	always_comb
	begin
		next_st = st;
		if (!enable)
		begin
			next_st.acc   = '0;
			next_st.level = 1'b0;
		end
		else if (st.acc + INC >= MOD)
		begin
			next_st.acc   = st.acc + INC - MOD;
			next_st.level = !st.level;
		end
		else
		begin
			next_st.acc = st.acc + INC;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign clockOut = st.level;

endmodule // mprgc_clock_gen

// *** hw/mprgc_top.sv ***
// Purpose: card power/reset sequencing and positioning receiver control
// Assumes: host pins sampled on mclk; Avalon-MM register slave
// Notes:   pulled pins are modelled by a driven flag per pin
//
// Functional notes
// - power request high powers card on
// - undriven power request reads low
// - card reset low holds power-on reset
// - undriven card reset reads high
// - software command performs normal power-off
// - reset runs SIM and memory shutdown
// - positioning off low disables, else software
// - undriven positioning off reads high
// - transmit blanking high while transmitting
// - continuous 32 kHz low power clock
// - 26 MHz aiding reference clock
// - one line powers and resets receiver
// - four-wire UART with RTS/CTS
// - transmit activity notified to receiver
// - cell timing strobe to receiver
// - position data over USB normally
// - position data over I2C during sleep
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`include "mprgc_map.svh"
module mprgc_top
	import mprgc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire mprgc_avreq_type  busReq,
	output mprgc_avrsp_type       busRsp,
	input  wire logic             powerRequest,
	input  wire logic             powerRequestDriven,
	input  wire logic             cardResetN,
	input  wire logic             cardResetDriven,
	input  wire logic             positioningOffN,
	input  wire logic             positioningOffDriven,
	input  wire logic             radioTxOn,
	input  wire logic             cellFrameTick,
	input  wire logic             uartRxLine,
	input  wire logic             uartCtsN,
	output logic                  cardPowered,
	output logic                  simEnable,
	output logic                  memCtrlEnable,
	output logic                  txBlanking,
	output logic                  positioningPowerCtrl,
	output logic                  lowPowerClock,
	output logic                  aidingRefClock,
	output logic                  txActivityNotice,
	output logic                  cellFrameStrobe,
	output logic                  uartTxLine,
	output logic                  uartRtsN,
	output logic                  usbPositionRoute,
	output logic                  i2cPositionRoute
);

	localparam logic [15:0] SIM_CYC  = 16'(`MPRGC_SIM_DOWN_CYC);
	localparam logic [15:0] MEM_CYC  = 16'(`MPRGC_MEM_DOWN_CYC);
	localparam logic [15:0] BIT_CYC  = 16'(`MPRGC_BIT_CYC);
	localparam logic [15:0] HALF_CYC = 16'(`MPRGC_BIT_CYC / 2);

	mprgc_state_type st;
	mprgc_state_type next_st;
	logic [2:0]      pinLevel;
	logic            pwrReqS;
	logic            rstNS;
	logic            posOffNS;
	logic            accept;
	logic            doWrite;
	logic            doRead;
	logic            offCmd;
	logic            nextOn;
	logic [31:0]     readMux;

	////////////////////////////////////////////////////////////////////////
	// pull resolution and synchronisers

	always_comb
	begin
		pinLevel[0] = powerRequestDriven ? powerRequest : 1'b0;
		pinLevel[1] = cardResetDriven ? cardResetN : 1'b1;
		pinLevel[2] = positioningOffDriven ? positioningOffN : 1'b1;
	end

	assign pwrReqS  = st.syncB[0];
	assign rstNS    = st.syncB[1];
	assign posOffNS = st.syncB[2];

	////////////////////////////////////////////////////////////////////////
	// bus decode

	assign accept  = (busReq.read || busReq.write) && st.waitreq;
	assign doWrite = busReq.write && !st.waitreq && busReq.byteenable[0];
	assign doRead  = busReq.read && !st.waitreq;
	assign offCmd  = doWrite && (busReq.address == `MPRGC_REG_CTRL)
		&& busReq.writedata[`MPRGC_CTRL_OFF_CMD];

	always_comb
	begin
		readMux = '0;
		unique case (busReq.address)
			`MPRGC_REG_CTRL:
			begin
				readMux[`MPRGC_CTRL_POS_EN] = st.posEnable;
				readMux[`MPRGC_CTRL_SLEEP]  = st.hostSleep;
			end
			`MPRGC_REG_STATUS:
			begin
				readMux[`MPRGC_ST_POWERED]  = st.cardPowered;
				readMux[`MPRGC_ST_POS_ACT]  = st.posPower;
				readMux[`MPRGC_ST_IN_RESET] = !rstNS;
				readMux[`MPRGC_ST_STATE_MSB:`MPRGC_ST_STATE_LSB] = st.pwr;
			end
			`MPRGC_REG_UART_TX:
				readMux[`MPRGC_UART_BUSY] = (st.txBits != '0)
					|| (st.txBaud != '0);
			`MPRGC_REG_UART_RX:
			begin
				readMux[7:0]                 = st.rxData;
				readMux[`MPRGC_UART_VALID]   = st.rxValid;
				readMux[`MPRGC_UART_OVERRUN] = st.rxOverrun;
			end
			default:
				readMux = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_st = st;

		next_st.syncA = pinLevel;
		next_st.syncB = st.syncA;

		// register slave, answer one cycle after the request
		if (accept)
		begin
			next_st.waitreq = 1'b0;
			next_st.rdata   = readMux;
		end
		else
		begin
			next_st.waitreq = 1'b1;
		end

		if (doWrite && busReq.address == `MPRGC_REG_CTRL)
		begin
			next_st.posEnable = busReq.writedata[`MPRGC_CTRL_POS_EN];
			next_st.hostSleep = busReq.writedata[`MPRGC_CTRL_SLEEP];
		end

		// power sequencing
		if (!pwrReqS)
			next_st.offLatch = 1'b0;
		if (st.stepCnt != '0)
			next_st.stepCnt = st.stepCnt - 16'h0001;

		unique case (st.pwr)
			PWR_OFF:
			begin
				if (!rstNS)
					next_st.pwr = PWR_HELD;
				else if (pwrReqS && !st.offLatch)
					next_st.pwr = PWR_ON;
			end
			PWR_ON:
			begin
				if (!rstNS)
				begin
					next_st.pwr     = PWR_SIM_DOWN;
					next_st.stepCnt = SIM_CYC;
				end
				else if (offCmd)
				begin
					next_st.pwr      = PWR_SIM_DOWN;
					next_st.stepCnt  = SIM_CYC;
					next_st.offLatch = 1'b1;
				end
				else if (!pwrReqS)
				begin
					next_st.pwr     = PWR_SIM_DOWN;
					next_st.stepCnt = SIM_CYC;
				end
			end
			PWR_SIM_DOWN:
			begin
				if (st.stepCnt == 16'h0001)
				begin
					next_st.pwr     = PWR_MEM_DOWN;
					next_st.stepCnt = MEM_CYC;
				end
			end
			PWR_MEM_DOWN:
			begin
				if (st.stepCnt == 16'h0001)
					next_st.pwr = rstNS ? PWR_OFF : PWR_HELD;
			end
			PWR_HELD:
			begin
				if (rstNS)
					next_st.pwr = PWR_OFF;
			end
			default:
				next_st.pwr = PWR_OFF;
		endcase

		nextOn = (next_st.pwr == PWR_ON);
		next_st.cardPowered = nextOn || (next_st.pwr == PWR_SIM_DOWN)
			|| (next_st.pwr == PWR_MEM_DOWN);
		next_st.simEnable = nextOn;
		next_st.memEnable = nextOn || (next_st.pwr == PWR_SIM_DOWN);

		// positioning receiver control
		next_st.posPower = nextOn && posOffNS && next_st.posEnable;
		next_st.txBlank  = nextOn && radioTxOn;
		next_st.txNotice = next_st.posPower && radioTxOn;
		next_st.frameStrobe = next_st.posPower && cellFrameTick;
		next_st.usbRoute = next_st.posPower && !next_st.hostSleep;
		next_st.i2cRoute = next_st.posPower && next_st.hostSleep;

		// uart transmit, start bit held back while CTS is deasserted
		if (doWrite && busReq.address == `MPRGC_REG_UART_TX
			&& st.txBits == '0 && st.txBaud == '0 && st.posPower)
		begin
			next_st.txShift = {1'b1, busReq.writedata[7:0], 1'b0};
			next_st.txBits  = `MPRGC_UART_BITS;
		end
		else if (st.txBaud != '0)
		begin
			next_st.txBaud = st.txBaud - 16'h0001;
		end
		else if (st.txBits != '0)
		begin
			if (st.txBits != `MPRGC_UART_BITS || !uartCtsN)
			begin
				next_st.txLine  = st.txShift[0];
				next_st.txShift = {1'b1, st.txShift[9:1]};
				next_st.txBits  = st.txBits - 4'h1;
				next_st.txBaud  = BIT_CYC - 16'h0001;
			end
		end
		if (!st.posPower && st.txBits == '0)
			next_st.txLine = 1'b1;

		// uart receive, sampled mid-bit
		if (doRead && busReq.address == `MPRGC_REG_UART_RX)
		begin
			next_st.rxValid   = 1'b0;
			next_st.rxOverrun = 1'b0;
		end
		if (!st.rxBusy)
		begin
			if (!uartRxLine && st.posPower)
			begin
				next_st.rxBusy = 1'b1;
				next_st.rxBits = '0;
				next_st.rxBaud = HALF_CYC;
			end
		end
		else if (st.rxBaud != '0)
		begin
			next_st.rxBaud = st.rxBaud - 16'h0001;
		end
		else if (st.rxBits == '0)
		begin
			next_st.rxBusy = !uartRxLine;
			next_st.rxBits = 4'h1;
			next_st.rxBaud = BIT_CYC - 16'h0001;
		end
		else if (st.rxBits != `MPRGC_UART_STOP)
		begin
			next_st.rxShift = {uartRxLine, st.rxShift[7:1]};
			next_st.rxBits  = st.rxBits + 4'h1;
			next_st.rxBaud  = BIT_CYC - 16'h0001;
		end
		else
		begin
			next_st.rxBusy = 1'b0;
			if (st.rxValid)
			begin
				next_st.rxOverrun = 1'b1;
				next_st.rxValid   = 1'b1;
			end
			else
			begin
				next_st.rxData  = st.rxShift;
				next_st.rxValid = 1'b1;
			end
		end
		next_st.rtsN = next_st.rxValid;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st           <= '0;
			st.syncA     <= `MPRGC_SYNC_IDLE;
			st.syncB     <= `MPRGC_SYNC_IDLE;
			st.pwr       <= PWR_OFF;
			st.waitreq   <= 1'b1;
			st.txLine    <= 1'b1;
			st.txShift   <= `MPRGC_TX_IDLE;
			st.posEnable <= `MPRGC_POS_EN_RST;
			st.hostSleep <= `MPRGC_SLEEP_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clocks to the positioning receiver

	mprgc_clock_gen
	#(
		.OUT_HZ (`MPRGC_LPO_HZ),
		.IN_HZ  (`MPRGC_CLK_HZ)
	)
	lowPowerGen
	(
		.mclk     (mclk),
		.rst_b    (rst_b),
		.enable   (1'b1),
		.clockOut (lowPowerClock)
	);

	mprgc_clock_gen
	#(
		.OUT_HZ (`MPRGC_AID_HZ),
		.IN_HZ  (`MPRGC_CLK_HZ)
	)
	aidingGen
	(
		.mclk     (mclk),
		.rst_b    (rst_b),
		.enable   (st.posPower),
		.clockOut (aidingRefClock)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign busRsp.readdata    = st.rdata;
	assign busRsp.waitrequest = st.waitreq;
	assign cardPowered          = st.cardPowered;
	assign simEnable            = st.simEnable;
	assign memCtrlEnable        = st.memEnable;
	assign txBlanking           = st.txBlank;
	assign positioningPowerCtrl = st.posPower;
	assign txActivityNotice     = st.txNotice;
	assign cellFrameStrobe      = st.frameStrobe;
	assign uartTxLine           = st.txLine;
	assign uartRtsN             = st.rtsN;
	assign usbPositionRoute     = st.usbRoute;
	assign i2cPositionRoute     = st.i2cRoute;

endmodule // mprgc_top

// *** verification/mprgc_props.sv ***
// Purpose: port assertions of mprgc_top
// Assumes: one clock domain, mclk
// Notes:   attached by bind from the bench
`timescale 1ns/10ps
module mprgc_props
	import mprgc_pkg::*;
(
	input wire logic	mclk,
	input wire logic	rst_b,
	input wire logic	powerRequest,
	input wire logic	powerRequestDriven,
	input wire logic	cardResetN,
	input wire logic	cardResetDriven,
	input wire logic	positioningOffN,
	input wire logic	positioningOffDriven,
	input wire logic	radioTxOn,
	input wire logic	cellFrameTick,
	input wire logic	cardPowered,
	input wire logic	simEnable,
	input wire logic	memCtrlEnable,
	input wire logic	txBlanking,
	input wire logic	positioningPowerCtrl,
	input wire logic	aidingRefClock,
	input wire logic	cellFrameStrobe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	property p_blank;
		txBlanking |-> $past(radioTxOn);
	endproperty
	a_blank: assert property (p_blank)
		else $error("blanking without transmit");
	property p_pos_off;
		(!positioningOffN && positioningOffDriven) [*5]
			|=> !positioningPowerCtrl;
	endproperty
	a_pos_off: assert property (p_pos_off)
		else $error("positioning powered while pin low");
	property p_aid;
		!positioningPowerCtrl [*2] |-> !aidingRefClock;
	endproperty
	a_aid: assert property (p_aid)
		else $error("aiding clock while positioning off");
	property p_strobe;
		cellFrameStrobe |-> $past(cellFrameTick);
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("strobe without cell tick");
	property p_sim_step;
		$fell(simEnable) |-> ##190 memCtrlEnable ##[1:20] !memCtrlEnable;
	endproperty
	a_sim_step: assert property (p_sim_step)
		else $error("sim shutdown step length wrong");
	property p_mem_step;
		$fell(memCtrlEnable) |-> ##190 cardPowered ##[1:20] !cardPowered;
	endproperty
	a_mem_step: assert property (p_mem_step)
		else $error("memory shutdown step length wrong");
	property p_reset_hold;
		(!cardResetN && cardResetDriven) [*5] |=> !simEnable;
	endproperty
	a_reset_hold: assert property (p_reset_hold)
		else $error("card active during reset");
	property p_req_low;
		(!powerRequest || !powerRequestDriven) [*5] |=> !simEnable;
	endproperty
	a_req_low: assert property (p_req_low)
		else $error("card active without power request");
	c_sim: cover property ($fell(simEnable));
	c_strobe: cover property (cellFrameStrobe);
	c_pos: cover property ($rose(positioningPowerCtrl));
endmodule // mprgc_props

// *** verification/mprgc_host_model.sv ***
// Purpose: host side of the card power pins
// Assumes: cmd 0 float, 1 power on, 2 orderly off
// Notes:   undriven pins show the level opposite the pull
`timescale 1ns/10ps
module mprgc_host_model
	import mprgc_pkg::*;
#(
	parameter int GAP = 4
)
(
	input  wire logic	mclk,
	input  wire logic	rst_b,
	input  wire logic [1:0]	cmd,
	output logic		powerRequest,
	output logic		powerRequestDriven,
	output logic		cardResetN,
	output logic		cardResetDriven
);
	int	gap;
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b || cmd == 2'h0)
		begin
			{powerRequest, powerRequestDriven} <= 2'h2;
			{cardResetN, cardResetDriven} <= 2'h0;
			gap <= 0;
		end
		else if (cmd == 2'h1)
		begin
			{powerRequest, powerRequestDriven} <= 2'h3;
			{cardResetN, cardResetDriven} <= 2'h3;
			gap <= 0;
		end
		else
		begin
			// reset first, supply request later
			{cardResetN, cardResetDriven} <= 2'h1;
			gap <= gap + 1;
			if (gap == GAP)
				powerRequest <= 1'b0;
		end
	end
endmodule // mprgc_host_model

// *** verification/testbench.sv ***
// Purpose: self-checking bench of mprgc_top
// Assumes: host model drives the power pins
// Notes:   uart tx looped back into rx
`timescale 1ns/10ps
`include "mprgc_map.svh"
bind mprgc_top mprgc_props mprgc_props_i (.mclk, .rst_b, .powerRequest,
	.powerRequestDriven, .cardResetN, .cardResetDriven, .positioningOffN,
	.positioningOffDriven, .radioTxOn, .cellFrameTick, .cardPowered,
	.simEnable, .memCtrlEnable, .txBlanking, .positioningPowerCtrl,
	.aidingRefClock, .cellFrameStrobe);
////////////////////////////////////////////////////////////////////////
module testbench import mprgc_pkg::*;;
	mprgc_avreq_type	busReq;
	mprgc_avrsp_type	busRsp;
	logic	mclk, rst_b, radioTxOn, cellFrameTick, uartRxLine, q;
	logic	positioningOffN, positioningOffDriven, uartCtsN;
	logic	powerRequest, powerRequestDriven, cardResetN;
	logic	cardResetDriven, cardPowered, simEnable, memCtrlEnable;
	logic	txBlanking, positioningPowerCtrl, lowPowerClock;
	logic	aidingRefClock, txActivityNotice, cellFrameStrobe;
	logic	uartTxLine, uartRtsN, usbPositionRoute, i2cPositionRoute;
	logic [1:0]	cmd;
	logic [31:0]	rd;
	int	num_errors, checks, n, p;
	mprgc_host_model mprgc_host_model_i (.mclk, .rst_b, .cmd,
		.powerRequest, .powerRequestDriven, .cardResetN, .cardResetDriven);
	mprgc_top mprgc_top_i (.mclk, .rst_b, .busReq, .busRsp, .powerRequest,
		.powerRequestDriven, .cardResetN, .cardResetDriven,
		.positioningOffN, .positioningOffDriven, .radioTxOn, .cellFrameTick,
		.uartRxLine, .uartCtsN, .cardPowered, .simEnable, .memCtrlEnable,
		.txBlanking, .positioningPowerCtrl, .lowPowerClock, .aidingRefClock,
		.txActivityNotice, .cellFrameStrobe, .uartTxLine, .uartRtsN,
		.usbPositionRoute, .i2cPositionRoute);
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk)
		uartRxLine <= uartTxLine;
	task automatic chk(input logic [31:0] s, e, input string nm);
		checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input int d);
		busReq <= '{!w, w, a, 4'hF, d};
		@(posedge mclk);
		while (busRsp.waitrequest !== 1'b0)
			@(posedge mclk);
		rd = busRsp.readdata;
		busReq <= '0;
		@(posedge mclk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#300000;
		num_errors++;
		complete_run;
	end
	initial
	begin
		{rst_b, radioTxOn, cellFrameTick, positioningOffN} = 4'h0;
		{positioningOffDriven, uartCtsN, q} = 3'h1;
		{num_errors, checks, cmd, busReq} = '0;
		cyc(2);
		rst_b <= 1'b1;
		cyc(2);
		bus(0, `MPRGC_REG_STATUS, 0);
		chk(rd, 32'h10, "status float");
		bus(0, 4'h2, 0);
		chk(rd, 0, "unmapped");
		cmd <= 2'h1;
		cyc(8);
		chk(cardPowered, 1, "powered");
		bus(0, `MPRGC_REG_STATUS, 0);
		chk(rd, 32'h21, "status on");
		$display("power-on test done");
		bus(1, `MPRGC_REG_CTRL, 1);
		cyc(6);
		chk(positioningPowerCtrl, 1, "pos on");
		chk(usbPositionRoute, 1, "usb route");
		bus(0, `MPRGC_REG_STATUS, 0);
		chk(rd, 32'h23, "status pos");
		radioTxOn <= 1'b1;
		cyc(3);
		chk(txBlanking, 1, "blank");
		chk(txActivityNotice, 1, "notice");
		radioTxOn <= 1'b0;
		cellFrameTick <= 1'b1;
		cyc(1);
		cellFrameTick <= 1'b0;
		cyc(1);
		chk(cellFrameStrobe, 1, "strobe");
		cyc(1);
		chk(cellFrameStrobe, 0, "strobe end");
		chk(txBlanking, 0, "blank end");
		n = 0;
		for (p = 0; p < 1000; p++)
		begin
			@(posedge mclk);
			n += (aidingRefClock && !q);
			q = aidingRefClock;
		end
		chk(n >= 129 && n <= 131, 1, "aid rate");
		p = 0;
		n = 0;
		q = 1'b1;
		while (n < 2)
		begin
			@(posedge mclk);
			n += (lowPowerClock && !q);
			p += (n == 1);
			q = lowPowerClock;
		end
		chk(p >= 6102 && p <= 6105, 1, "lpo period");
		$display("positioning test done");
		bus(1, `MPRGC_REG_UART_TX, 32'hA5);
		bus(0, `MPRGC_REG_UART_TX, 0);
		chk(rd, 32'h100, "tx busy");
		while (uartRtsN !== 1'b1)
			@(posedge mclk);
		bus(0, `MPRGC_REG_UART_RX, 0);
		chk(rd, 32'h1A5, "uart byte");
		cyc(2);
		chk(uartRtsN, 0, "rts free");
		bus(1, `MPRGC_REG_CTRL, 3);
		cyc(3);
		chk(i2cPositionRoute, 1, "i2c route");
		positioningOffDriven <= 1'b1;
		cyc(6);
		chk(positioningPowerCtrl, 0, "pin off");
		cyc(2);
		chk(aidingRefClock, 0, "aid off");
		positioningOffDriven <= 1'b0;
		$display("uart test done");
		bus(1, `MPRGC_REG_CTRL, 4);
		cyc(420);
		chk(cardPowered, 0, "sw off");
		cmd <= 2'h0;
		cyc(6);
		cmd <= 2'h1;
		cyc(8);
		chk(cardPowered, 1, "re-on");
		cmd <= 2'h2;
		cyc(8);
		chk(simEnable, 0, "sim down");
		chk(memCtrlEnable, 1, "mem hold");
		cyc(205);
		chk(memCtrlEnable, 0, "mem down");
		chk(cardPowered, 1, "still up");
		cyc(200);
		chk(cardPowered, 0, "off");
		bus(0, `MPRGC_REG_STATUS, 0);
		chk(rd, 32'h104, "held");
		$display("shutdown test done");
		complete_run;
	end
endmodule // testbench
